// ===== rtl/servo_ctrl.sv
// servo enable, rotation direction and overtravel control with apb access
`timescale 1ns/10ps
module servo_ctrl (
    input wire logic clock,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic mainPowerOn,
    input wire logic servoOnInput,
    input wire logic forwardLimitInput,
    input wire logic reverseLimitInput,
    input wire logic alarmInput,
    input wire logic encoderPhaseA,
    input wire logic encoderPhaseB,
    input wire logic cmdForward,
    input wire logic cmdReverse,
    output logic motorEnergized,
    output logic motorCcw,
    output logic motorCw,
    output logic brakeControlOutput,
    output logic zeroHoldActive,
    output logic fwdOvertravel,
    output logic revOvertravel,
    output logic encoderOutPhaseA,
    output logic encoderOutPhaseB,
    output servo_ctrl_pkg::drive_state_t driveState,
    output logic irq
);
    import servo_ctrl_pkg::*;

    localparam logic [`STOP_TIMER_W-1:0] STOP_CYC =
        `STOP_TIMER_W'(`STOP_CYCLES);

    servo_regs_t st;
    servo_regs_t next_st;

    logic [6:0] pinSync;
    logic powerS;
    logic servoOnS;
    logic fwdOtS;
    logic revOtS;
    logic alarmS;
    logic encAS;
    logic encBS;

    // every pin but the two commands crosses two flops before any logic reads it; limits enter
    // inverted so the flushed synchroniser reads as permitted, not overtravel
    sync_two_stage #(
        .WIDTH(7)
    ) u_pin_sync (
        .clock(clock),
        .rst(rst),
        .async({mainPowerOn, servoOnInput, ~forwardLimitInput,
            ~reverseLimitInput, alarmInput, encoderPhaseA, encoderPhaseB}),
        .synced(pinSync)
    );

    assign {powerS, servoOnS, fwdOtS, revOtS, alarmS, encAS, encBS}
        = pinSync;

    logic fwdOt;
    logic revOt;
    logic servoOnActive;
    logic energizeReq;
    logic otHit;
    logic fwdDrive;
    logic revDrive;
    logic apbAccess;
    logic apbWrite;
    logic [31:0] readWord;
    logic mapped;
    logic [`EV_COUNT-1:0] events;
    logic [`EV_COUNT-1:0] irqClear;
    logic alarmReset;
    logic otInState;

    always_comb
    begin
        next_st = st;

        // a limit input that is off means the axis ran past it
        fwdOt = fwdOtS;
        revOt = revOtS;

        // code 9 pins servo-on high; any other code follows the pin
        if (st.inputAssignmentParamA == `SON_ALWAYS)
        begin
            servoOnActive = 1'b1;
        end
        else
        begin
            servoOnActive = servoOnS;
        end

        // a latched alarm drops drive until reset; power and servo-on gate it too
        energizeReq = powerS && servoOnActive && !st.alarmLatched;

        // the limit is picked by the command, whatever the rotation
        otHit = (cmdForward && fwdOt) || (cmdReverse && revOt);
        fwdDrive = cmdForward && !cmdReverse && !fwdOt;
        revDrive = cmdReverse && !cmdForward && !revOt;

        // apb: one wait state, the write lands on the completing edge
        apbAccess = psel && penable && st.pready;
        apbWrite = apbAccess && pwrite;
        mapped = 1'b1;
        case (paddr)
            `OFS_CONFIG:
            begin
                readWord = {26'h0, st.shadowStopMethod,
                    st.shadowDirectionSelect, st.shadowServoOnAssign};
            end
            `OFS_ACTIVE:
            begin
                readWord = {26'h0, st.stopMethodParam,
                    st.directionSelectParam, st.inputAssignmentParamA};
            end
            `OFS_STATUS:
            begin
                readWord = {22'h0, st.state, st.alarmLatched, revOt, fwdOt,
                    st.brakeControlOutput, st.zeroHoldActive, st.motorCw,
                    st.motorCcw, st.motorEnergized};
            end
            `OFS_CONTROL:
            begin
                readWord = `WORD_ZERO;
            end
            `OFS_IRQ_STATUS:
            begin
                readWord = {28'h0, st.irqStatus};
            end
            `OFS_IRQ_MASK:
            begin
                readWord = {28'h0, st.irqMask};
            end
            default:
            begin
                readWord = `WORD_ZERO;
                mapped = 1'b0;
            end
        endcase

        next_st.pready = psel && penable && !st.pready;
        if (psel && penable && !st.pready)
        begin
            next_st.prdata = pwrite ? `WORD_ZERO : readWord;
            next_st.pslverr = !mapped;
        end
        else
        begin
            next_st.prdata = `WORD_ZERO;
            next_st.pslverr = 1'b0;
        end

        irqClear = '0;
        alarmReset = 1'b0;
        if (apbWrite)
        begin
            case (paddr)
                `OFS_CONFIG:
                begin
                    next_st.shadowServoOnAssign =
                        pwdata[`CFG_SON_MSB:`CFG_SON_LSB];
                    next_st.shadowDirectionSelect = pwdata[`CFG_DIR_BIT];
                    next_st.shadowStopMethod = pwdata[`CFG_HOLD_BIT];
                end
                `OFS_CONTROL:
                begin
                    alarmReset = pwdata[`CTL_ALARM_RESET_BIT];
                end
                `OFS_IRQ_STATUS:
                begin
                    irqClear = pwdata[`EV_COUNT-1:0];
                end
                `OFS_IRQ_MASK:
                begin
                    next_st.irqMask = pwdata[`EV_COUNT-1:0];
                end
                default:
                begin
                    alarmReset = 1'b0;
                end
            endcase
        end

        // setup fields move to the live copy only on a power restart
        next_st.powerPrev = powerS;
        if (powerS && !st.powerPrev)
        begin
            next_st.inputAssignmentParamA = st.shadowServoOnAssign;
            next_st.directionSelectParam = st.shadowDirectionSelect;
            next_st.stopMethodParam = st.shadowStopMethod;
        end

        // alarm still present wins over a reset in the same cycle
        next_st.alarmPrev = alarmS;
        next_st.alarmLatched = alarmS || (st.alarmLatched && !alarmReset);

        next_st.stopTimer = st.stopTimer;
        case (st.state)
            ST_OFF:
            begin
                if (energizeReq)
                begin
                    next_st.state = ST_RUN;
                end
            end
            ST_RUN:
            begin
                if (!energizeReq)
                begin
                    next_st.state = ST_OFF;
                end
                else if (otHit)
                begin
                    next_st.state = ST_STOPPING;
                    next_st.stopTimer = STOP_CYC;
                end
            end
            ST_STOPPING:
            begin
                if (!energizeReq)
                begin
                    next_st.state = ST_OFF;
                end
                else if (st.stopTimer <= `STOP_TIMER_W'(1))
                begin
                    next_st.state = ST_HALTED;
                    next_st.stopTimer = '0;
                end
                else
                begin
                    next_st.stopTimer = st.stopTimer - `STOP_TIMER_W'(1);
                end
            end
            ST_HALTED:
            begin
                if (!energizeReq)
                begin
                    next_st.state = ST_OFF;
                end
                else if (!otHit)
                begin
                    next_st.state = ST_RUN;
                end
            end
            default:
            begin
                next_st.state = ST_OFF;
            end
        endcase

        // outputs follow the next state so each leaves a flop
        otInState = (next_st.state == ST_STOPPING) ||
            (next_st.state == ST_HALTED);
        next_st.motorEnergized = (next_st.state == ST_RUN) ||
            (next_st.state == ST_STOPPING) ||
            (next_st.state == ST_HALTED && next_st.stopMethodParam);
        next_st.zeroHoldActive = (next_st.state == ST_HALTED) &&
            next_st.stopMethodParam;
        next_st.brakeControlOutput = (next_st.state != ST_RUN);
        if (next_st.state == ST_RUN)
        begin
            // reverse mode swaps the physical sense of both commands
            // the live copy that loads on this edge already steers it
            next_st.motorCcw = next_st.directionSelectParam ? revDrive
                : fwdDrive;
            next_st.motorCw = next_st.directionSelectParam ? fwdDrive
                : revDrive;
        end
        else
        begin
            next_st.motorCcw = 1'b0;
            next_st.motorCw = 1'b0;
        end
        next_st.fwdOvertravel = fwdOt;
        next_st.revOvertravel = revOt;

        // swapping the phases undoes the reversed physical lead
        next_st.encoderOutPhaseA = st.directionSelectParam ? encBS
            : encAS;
        next_st.encoderOutPhaseB = st.directionSelectParam ? encAS
            : encBS;

        next_st.fwdOtPrev = fwdOt;
        next_st.revOtPrev = revOt;
        events = '0;
        events[`EV_FWD_OT] = fwdOt && !st.fwdOtPrev;
        events[`EV_REV_OT] = revOt && !st.revOtPrev;
        events[`EV_ALARM] = alarmS && !st.alarmPrev;
        events[`EV_STOPPED] = otInState && (next_st.state == ST_HALTED) &&
            (st.state == ST_STOPPING);
        // a new event beats a clear written in the same cycle
        next_st.irqStatus = (st.irqStatus & ~irqClear) | events;
        next_st.irq = |(next_st.irqStatus & next_st.irqMask);
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            st <= '0;
            st.state <= ST_OFF;
            st.shadowServoOnAssign <= `SON_DEFAULT;
            st.shadowDirectionSelect <= `DIR_DEFAULT;
            st.shadowStopMethod <= `HOLD_DEFAULT;
            st.inputAssignmentParamA <= `SON_DEFAULT;
            st.directionSelectParam <= `DIR_DEFAULT;
            st.stopMethodParam <= `HOLD_DEFAULT;
            st.irqStatus <= `IRQ_DEFAULT;
            st.irqMask <= `IRQ_DEFAULT;
            st.brakeControlOutput <= 1'b1;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign prdata = st.prdata;
    assign pready = st.pready;
    assign pslverr = st.pslverr;
    assign motorEnergized = st.motorEnergized;
    assign motorCcw = st.motorCcw;
    assign motorCw = st.motorCw;
    assign brakeControlOutput = st.brakeControlOutput;
    assign zeroHoldActive = st.zeroHoldActive;
    assign fwdOvertravel = st.fwdOvertravel;
    assign revOvertravel = st.revOvertravel;
    assign encoderOutPhaseA = st.encoderOutPhaseA;
    assign encoderOutPhaseB = st.encoderOutPhaseB;
    assign driveState = st.state;
    assign irq = st.irq;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    property p_input_follow;
        (st.inputAssignmentParamA == `SON_INPUT && !servoOnS &&
            st.state != ST_OFF) |=> st.state == ST_OFF;
    endproperty
    a_input_follow: assert property (p_input_follow)
        else $error("servo-on input off did not de-energize");

    property p_always_on;
        (st.inputAssignmentParamA == `SON_ALWAYS && powerS &&
            !st.alarmLatched && st.state == ST_OFF) |=> st.state == ST_RUN;
    endproperty
    a_always_on: assert property (p_always_on)
        else $error("permanent servo-on did not energize");

    property p_alarm_recover;
        (st.inputAssignmentParamA == `SON_ALWAYS && st.alarmLatched &&
            alarmReset && !alarmS && powerS && st.state == ST_OFF)
            |=> ##1 st.state == ST_RUN ##1 motorEnergized;
    endproperty
    a_alarm_recover: assert property (p_alarm_recover)
        else $error("alarm reset did not restore energized state");

    property p_dir_default;
        (st.state == ST_RUN && !st.directionSelectParam &&
            $past(fwdDrive)) |-> motorCcw && !motorCw;
    endproperty
    a_dir_default: assert property (p_dir_default)
        else $error("forward command did not turn counterclockwise");

    property p_dir_reverse;
        (st.state == ST_RUN && st.directionSelectParam &&
            $past(fwdDrive)) |-> motorCw && !motorCcw;
    endproperty
    a_dir_reverse: assert property (p_dir_reverse)
        else $error("reversed mode did not swap rotation");

    property p_encoder_lead;
        st.directionSelectParam && $stable(st.directionSelectParam)
            |-> encoderOutPhaseA == $past(encBS);
    endproperty
    a_encoder_lead: assert property (p_encoder_lead)
        else $error("encoder phases not swapped in reverse mode");

    property p_ot_stop;
        (st.state == ST_RUN && energizeReq && cmdForward && fwdOt)
            |=> st.state == ST_STOPPING && !motorCcw && !motorCw;
    endproperty
    a_ot_stop: assert property (p_ot_stop)
        else $error("forward overtravel did not stop the motor");

    property p_rev_block;
        (st.state == ST_RUN && cmdReverse && revOt)
            |=> !motorCcw && !motorCw;
    endproperty
    a_rev_block: assert property (p_rev_block)
        else $error("reverse overtravel still drives");

    property p_brake;
        (st.state == ST_STOPPING || st.state == ST_HALTED)
            |-> brakeControlOutput;
    endproperty
    a_brake: assert property (p_brake)
        else $error("brake released during overtravel");

    property p_base_block;
        $rose(st.state == ST_STOPPING) && energizeReq && otHit &&
            !st.stopMethodParam |-> ##100 st.state == ST_HALTED &&
            !motorEnergized;
    endproperty
    a_base_block: assert property (p_base_block)
        else $error("no base block after overtravel stop");

    property p_setup_hold;
        !(powerS && !st.powerPrev) |=> $stable(st.inputAssignmentParamA);
    endproperty
    a_setup_hold: assert property (p_setup_hold)
        else $error("setup field changed without power restart");

    c_energize: cover property ($rose(motorEnergized));
    c_ot_halt: cover property (st.state == ST_STOPPING ##[1:200]
        st.state == ST_HALTED);
    c_hold: cover property (zeroHoldActive);
    c_irq: cover property ($rose(irq));
endmodule

// ===== rtl/servo_ctrl_consts.svh
// constants for the servo enable, direction and overtravel block
`ifndef SERVO_CTRL_CONSTS_SVH
`define SERVO_CTRL_CONSTS_SVH

// register byte offsets
`define OFS_CONFIG 8'h00
`define OFS_ACTIVE 8'h04
`define OFS_STATUS 8'h08
`define OFS_CONTROL 8'h0C
`define OFS_IRQ_STATUS 8'h10
`define OFS_IRQ_MASK 8'h14

// config field layout
`define CFG_SON_MSB 3
`define CFG_SON_LSB 0
`define CFG_DIR_BIT 4
`define CFG_HOLD_BIT 5

// servo-on assignment codes
`define SON_INPUT 4'h0
`define SON_ALWAYS 4'h9

// reset values
`define SON_DEFAULT 4'h0
`define DIR_DEFAULT 1'b0
`define HOLD_DEFAULT 1'b0
`define IRQ_DEFAULT 4'h0
`define WORD_ZERO 32'h0000_0000

// control register: write one to reset a latched alarm
`define CTL_ALARM_RESET_BIT 0

// interrupt event bit positions
`define EV_FWD_OT 0
`define EV_REV_OT 1
`define EV_ALARM 2
`define EV_STOPPED 3
`define EV_COUNT 4

// stop settle time before base block or hold
`define CLK_PERIOD_NS 10
`define STOP_TIME_NS 1000
`define STOP_CYCLES ((`STOP_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STOP_TIMER_W 8

`endif

// ===== rtl/servo_ctrl_pkg.sv
// types shared by the servo enable, direction and overtravel block
package servo_ctrl_pkg;

`include "servo_ctrl_consts.svh"

typedef enum logic [1:0] {
    ST_OFF = 2'b00,
    ST_RUN = 2'b01,
    ST_STOPPING = 2'b10,
    ST_HALTED = 2'b11
} drive_state_t;

typedef struct packed {
    drive_state_t state;
    logic [`STOP_TIMER_W-1:0] stopTimer;
    logic [3:0] shadowServoOnAssign;
    logic shadowDirectionSelect;
    logic shadowStopMethod;
    logic [3:0] inputAssignmentParamA;
    logic directionSelectParam;
    logic stopMethodParam;
    logic powerPrev;
    logic fwdOtPrev;
    logic revOtPrev;
    logic alarmPrev;
    logic alarmLatched;
    logic [`EV_COUNT-1:0] irqStatus;
    logic [`EV_COUNT-1:0] irqMask;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic motorEnergized;
    logic motorCcw;
    logic motorCw;
    logic brakeControlOutput;
    logic zeroHoldActive;
    logic fwdOvertravel;
    logic revOvertravel;
    logic encoderOutPhaseA;
    logic encoderOutPhaseB;
    logic irq;
} servo_regs_t;

endpackage

// ===== rtl/sync_two_stage.sv
// two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/10ps
module sync_two_stage #(
    parameter int WIDTH = 1
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [WIDTH-1:0] async,
    output logic [WIDTH-1:0] synced
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } sync_regs_t;

    sync_regs_t st;
    sync_regs_t next_st;

    always_comb
    begin
        next_st.meta = async;
        next_st.stable = st.meta;
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign synced = st.stable;
endmodule

// ===== tb/limit_switch_model.sv
// limit switch pair wired as normally closed contacts
`timescale 1ns/10ps
module limit_switch_model (
    input wire logic atFwdEnd,
    input wire logic atRevEnd,
    output logic forwardLimitInput,
    output logic reverseLimitInput
);
    // contact opens at the end stop, so a cut wire also reads as overtravel
    assign forwardLimitInput = ~atFwdEnd;
    assign reverseLimitInput = ~atRevEnd;
endmodule

// ===== tb/servo_enable_direction_overtravel_tb.sv
// self-checking bench for the servo enable, direction and overtravel block
`timescale 1ns/10ps
`include "servo_ctrl_consts.svh"
module servo_enable_direction_overtravel_tb;
import servo_ctrl_pkg::*;
typedef struct packed {
    logic son;
    logic dir;
    logic cf;
    logic cr;
    logic [2:0] exp;
} row_t;
logic clock = 1'h0;
logic rst = 1'h1;
logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
logic [7:0] paddr = 8'h00;
logic [31:0] pwdata = 32'h0, prdata, rd;
logic pready, pslverr, er, irq, holdOn, curDir;
logic mainPowerOn = 1'h0, servoOnInput = 1'h0, alarmInput = 1'h0;
logic fwdEnd = 1'h0, revEnd = 1'h0, cmdForward = 1'h0, cmdReverse = 1'h0;
logic forwardLimitInput, reverseLimitInput;
logic [2:0] encCnt = 3'h0;
logic [5:0] encHist = 6'h0;
logic encOutA, encOutB;
logic motorEnergized, motorCcw, motorCw, brakeControlOutput;
logic zeroHoldActive, fwdOvertravel, revOvertravel;
drive_state_t driveState;
int miscompares = 0;
int numChecks = 0;
row_t row;
// columns: servo-on, reverse dir, fwd cmd, rev cmd, {energized, ccw, cw}
row_t rows [6] = '{7'h56, 7'h4D, 7'h44, 7'h75, 7'h6E, 7'h30};

always #5 clock = ~clock;

// quadrature pulses keep the encoder path busy
always @(posedge clock)
    encCnt <= encCnt + 3'h1;

// pin pairs as the block sees them; outputs trail by two sync flops and one
always @(posedge clock)
    encHist <= {encHist[3:0], encCnt[2], encCnt[2] ^ encCnt[1]};

limit_switch_model limit_switch_model_i (
    .atFwdEnd(fwdEnd),
    .atRevEnd(revEnd),
    .forwardLimitInput(forwardLimitInput),
    .reverseLimitInput(reverseLimitInput)
);

servo_ctrl servo_ctrl_i (
    .clock(clock),
    .rst(rst),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .mainPowerOn(mainPowerOn),
    .servoOnInput(servoOnInput),
    .forwardLimitInput(forwardLimitInput),
    .reverseLimitInput(reverseLimitInput),
    .alarmInput(alarmInput),
    .encoderPhaseA(encCnt[2]),
    .encoderPhaseB(encCnt[2] ^ encCnt[1]),
    .cmdForward(cmdForward),
    .cmdReverse(cmdReverse),
    .motorEnergized(motorEnergized),
    .motorCcw(motorCcw),
    .motorCw(motorCw),
    .brakeControlOutput(brakeControlOutput),
    .zeroHoldActive(zeroHoldActive),
    .fwdOvertravel(fwdOvertravel),
    .revOvertravel(revOvertravel),
    .encoderOutPhaseA(encOutA),
    .encoderOutPhaseB(encOutB),
    .driveState(driveState),
    .irq(irq)
);

task summarize;
    $display("checks %0d miscompares %0d", numChecks, miscompares);
    if (miscompares == 0 && numChecks > 0)
        $display("SIMULATION PASSED");
    else
        $display("SIMULATION FAILED");
    $finish;
endtask

task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    numChecks++;
    if (got !== exp)
    begin
        miscompares++;
        $display("[ERR] %0t %s got %h exp %h", $time, msg, got, exp);
    end
endtask

task waitc(input int n);
    repeat (n) @(posedge clock);
    #1;
endtask

// one apb transfer; waits for pready under a bound
task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'h1;
    n = 0;
    do
    begin
        @(posedge clock);
        n++;
    end
    while (pready !== 1'h1 && n < 20);
    rd = prdata;
    er = pslverr;
    if (pready !== 1'h1)
        chk(32'h0, 32'h1, "no pready");
    psel <= 1'h0;
    penable <= 1'h0;
endtask

task setIn(input logic son, input logic cf, input logic cr);
    @(posedge clock);
    servoOnInput <= son;
    cmdForward <= cf;
    cmdReverse <= cr;
endtask

task pwrCycle;
    @(posedge clock);
    mainPowerOn <= 1'h0;
    waitc(4);
    @(posedge clock);
    mainPowerOn <= 1'h1;
    waitc(5);
endtask

task setCfg(input logic [31:0] d);
    apb(1'h1, `OFS_CONFIG, d);
    pwrCycle();
endtask

// drive into a limit and, when stop is set, follow the stop sequence; otherwise check the drive stays running
task ot(input logic cf, input logic cr, input logic fe, input logic re,
        input logic stop);
    setIn(1'h1, cf, cr);
    waitc(4);
    @(posedge clock);
    fwdEnd <= fe;
    revEnd <= re;
    waitc(4);
    if (stop)
    begin
        chk({30'h0, driveState}, {30'h0, ST_STOPPING}, "stop");
        chk({27'h0, brakeControlOutput, motorCcw, motorCw, fwdOvertravel,
            revOvertravel}, {27'h0, 3'h4, fe, re}, "ot outs");
        waitc(`STOP_CYCLES - 5);
        chk({30'h0, driveState}, {30'h0, ST_STOPPING}, "early");
        waitc(8);
        chk({30'h0, driveState}, {30'h0, ST_HALTED}, "halt");
        chk({30'h0, motorEnergized, zeroHoldActive},
            {30'h0, holdOn, holdOn}, "hold");
    end
    else
        chk({30'h0, driveState}, {30'h0, ST_RUN}, "opposite");
    @(posedge clock);
    fwdEnd <= 1'h0;
    revEnd <= 1'h0;
    setIn(1'h1, 1'h0, 1'h0);
    waitc(5);
    chk({30'h0, driveState}, {30'h0, ST_RUN}, "resume");
    $display("test overtravel done");
endtask

initial
begin
    #300000;
    chk(32'h0, 32'h1, "watchdog");
    summarize();
end

initial
begin
    holdOn = 1'h0;
    curDir = 1'h0;
    repeat (5) @(posedge clock);
    #1;
    chk({31'h0, brakeControlOutput}, 32'h1, "brake rst");
    chk({30'h0, driveState}, {30'h0, ST_OFF}, "state rst");
    @(posedge clock);
    rst <= 1'h0;
    mainPowerOn <= 1'h1;
    waitc(5);
    apb(1'h0, `OFS_CONFIG, 32'h0);
    chk(rd, `WORD_ZERO, "cfg rst");
    apb(1'h0, `OFS_IRQ_MASK, 32'h0);
    chk(rd, `WORD_ZERO, "mask rst");
    apb(1'h0, 8'h18, 32'h0);
    chk({31'h0, er}, 32'h1, "unmapped err");
    chk(rd, `WORD_ZERO, "unmapped data");
    $display("test reset done");
    for (int i = 0; i < 6; i++)
    begin
        row = rows[i];
        if (row.dir !== curDir)
        begin
            setCfg({27'h0, row.dir, 4'h0});
            curDir = row.dir;
        end
        setIn(row.son, row.cf, row.cr);
        waitc(5);
        chk({29'h0, motorEnergized, motorCcw, motorCw},
            {29'h0, row.exp}, "row");
        chk({30'h0, encOutA, encOutB}, {30'h0, curDir ?
            {encHist[4], encHist[5]} : encHist[5:4]}, "enc");
    end
    $display("test rows done");
    setIn(1'h0, 1'h0, 1'h0);
    apb(1'h1, `OFS_CONFIG, 32'h0);
    apb(1'h0, `OFS_ACTIVE, 32'h0);
    chk(rd, 32'h10, "active held");
    pwrCycle();
    apb(1'h0, `OFS_ACTIVE, 32'h0);
    chk(rd, 32'h0, "active new");
    $display("test power restart done");
    setCfg({28'h0, `SON_ALWAYS});
    chk({31'h0, motorEnergized}, 32'h1, "always on");
    apb(1'h1, `OFS_IRQ_STATUS, 32'hF);
    apb(1'h1, `OFS_IRQ_MASK, 32'h4);
    @(posedge clock);
    alarmInput <= 1'h1;
    waitc(5);
    chk({30'h0, motorEnergized, irq}, 32'h1, "alarm");
    @(posedge clock);
    alarmInput <= 1'h0;
    waitc(5);
    chk({31'h0, motorEnergized}, 32'h0, "latched");
    // commands stay off while the reset re-energizes the motor
    apb(1'h1, `OFS_CONTROL, 32'h1);
    waitc(4);
    chk({31'h0, motorEnergized}, 32'h1, "auto on");
    apb(1'h1, `OFS_IRQ_STATUS, 32'h4);
    waitc(3);
    chk({31'h0, irq}, 32'h0, "irq clr");
    $display("test permanent on done");
    setCfg(32'h0);
    ot(1'h1, 1'h0, 1'h1, 1'h0, 1'h1);
    ot(1'h0, 1'h1, 1'h1, 1'h0, 1'h0);
    ot(1'h0, 1'h1, 1'h0, 1'h1, 1'h1);
    holdOn = 1'h1;
    setCfg(32'h30);
    ot(1'h1, 1'h0, 1'h1, 1'h0, 1'h1);
    // reset in mid-run: limits idle permitted, so no false overtravel
    @(posedge clock);
    rst <= 1'h1;
    waitc(3);
    chk({30'h0, driveState}, {30'h0, ST_OFF}, "state mid rst");
    @(posedge clock);
    rst <= 1'h0;
    waitc(1);
    chk({29'h0, fwdOvertravel, revOvertravel, brakeControlOutput},
        32'h1, "first edge");
    apb(1'h0, `OFS_IRQ_STATUS, 32'h0);
    chk(rd, `WORD_ZERO, "no false event");
    $display("test mid reset done");
    summarize();
end
endmodule
